// ==== imia_pkg.sv ====
// Constants, register map and types for the multiply and increment data ALU
package imia_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_OPND1 = 8'h00;
  localparam logic [7:0] OFS_OPND2 = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_MEMW = 8'h0c;
  localparam logic [7:0] OFS_A_EXT = 8'h10;
  localparam logic [7:0] OFS_A_UPR = 8'h14;
  localparam logic [7:0] OFS_A_LWR = 8'h18;
  localparam logic [7:0] OFS_B_EXT = 8'h1c;
  localparam logic [7:0] OFS_B_UPR = 8'h20;
  localparam logic [7:0] OFS_B_LWR = 8'h24;
  localparam logic [7:0] OFS_CMD = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_INFO = 8'h30;
  // Status register bit positions (cond_code_byte)
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_U = 4;
  localparam int FLG_E = 5;
  localparam int FLG_L = 6;
  localparam int FLG_SZ = 7;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // Oscillator cycles and program words per operation
  localparam logic [3:0] CYC_MUL = 4'h2;
  localparam logic [3:0] CYC_INC_REG = 4'h2;
  localparam logic [3:0] CYC_INC_STACK = 4'h8;
  localparam logic [3:0] CYC_INC_SHORT = 4'h6;
  localparam logic [3:0] CYC_INC_ABS = 4'h8;
  localparam logic [3:0] CYC_INC_PAR = 4'h2;
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  // Integer ceilings
  localparam logic [19:0] MAX_POS20 = 20'h7ffff;
  localparam logic [15:0] MAX_POS16 = 16'h7fff;
  // Types
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} imia_state_t;
  typedef enum logic {OP_MUL = 1'b0, OP_INC = 1'b1} imia_op_t;
  typedef enum logic [1:0] {DST_A = 2'h0, DST_B = 2'h1, DST_REG = 2'h2, DST_MEM = 2'h3}
    imia_dest_t;
  typedef enum logic [1:0] {AM_STACK = 2'h0, AM_SHORT = 2'h1, AM_ABS = 2'h2,
    AM_RSVD = 2'h3} imia_mode_t;
  typedef struct packed {
    logic lim;
    logic par;
    imia_mode_t mode;
    imia_dest_t dest;
    imia_op_t op;
  } imia_cmd_t;
  typedef struct packed {
    logic [3:0] ext;
    logic [15:0] upr;
    logic [15:0] lwr;
  } imia_acc_t;
endpackage

// ==== imia_alu.sv ====
// APB-controlled integer multiply and word increment data ALU
// How it works
// - Multiply takes two signed 16-bit operands and keeps only the low 16 product bits.
// - An accumulator destination gets the product in its upper word, sign in extension, lower kept.
// - The product is a 16-bit signed value sign-extended to 20 bits, never saturated or rounded.
// - Swapping the two multiply operands gives the same result.
// - Overflow is set when the true signed product does not fit in 16 bits.
// - Multiply sets zero from the top 20 result bits and negative from bit 35.
// - Multiply is one word and two oscillator cycles.
// - Accumulator increment adds one to extension plus upper word, lower word kept.
// - Increment sets carry on carry out of bit 35 and overflow on signed overflow.
// - Increment sets zero when the top 20 result bits are all zero.
// - Increment sets extension when the integer part is in use, unnormalized when unnormalized.
// - Increment sets limit on parallel-move limiting or overflow and sets the sticky size flag on a parallel move only.
// - Register increment is 2 cycles 1 word; memory is 8/1 stack, 6/1 short, 8/2 absolute.
// - Accumulator increment with a parallel move is one word and one instruction cycle in any mode.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module imia_alu (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [imia_pkg::ADDR_W-1:0] paddr,
  input wire logic [imia_pkg::DATA_W-1:0] pwdata,
  output logic [imia_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import imia_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  imia_state_t state_q, state_d;
  imia_cmd_t cmd_q, cmd_d;
  imia_acc_t acc_q [2];
  imia_acc_t acc_d [2];
  logic [15:0] opnd1_q, opnd1_d;
  logic [15:0] opnd2_q, opnd2_d;
  logic [15:0] wreg_q, wreg_d;
  logic [15:0] memw_q, memw_d;
  logic [15:0] status_q, status_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] last_cyc_q, last_cyc_d;
  logic [1:0] last_words_q, last_words_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  // Accumulators are kept as three fields so each part loads on its own
  logic signed [31:0] prod;
  logic [15:0] mul16;
  logic [19:0] mul20;
  logic mul_ovf;
  logic acc_dst;
  logic acc_sel;
  logic [19:0] src20;
  logic [15:0] src16;
  logic [20:0] sum21;
  logic [16:0] sum17;
  logic [15:0] flags_mul;
  logic [15:0] flags_inc;
  logic [3:0] cyc_need;
  logic [1:0] words_need;

  // Product of signed operands; multiply is commutative so order is free
  assign prod = $signed(opnd1_q) * $signed(opnd2_q);
  assign mul16 = prod[15:0];
  // No saturation or rounding, just sign extension to 20 bits
  assign mul20 = {{4{mul16[15]}}, mul16};
  // Fits in 16 bits only if bits 31..15 are all equal
  assign mul_ovf = ~((&prod[31:15]) | ~(|prod[31:15]));
  assign acc_dst = (cmd_q.dest == DST_A) || (cmd_q.dest == DST_B);
  assign acc_sel = (cmd_q.dest == DST_B);
  assign src16 = (cmd_q.dest == DST_MEM) ? memw_q : wreg_q;
  assign src20 = {acc_q[acc_sel].ext, acc_q[acc_sel].upr};
  // Increment touches the upper 20 bits only; carry out is bit 20
  assign sum21 = {1'b0, src20} + 21'h000001;
  assign sum17 = {1'b0, src16} + 17'h00001;

  // Multiply flags: N, Z, V, L change; the rest hold
  always_comb begin
    flags_mul = status_q;
    flags_mul[FLG_N] = mul20[19];
    flags_mul[FLG_Z] = (mul20 == 20'h00000);
    flags_mul[FLG_V] = mul_ovf;
    flags_mul[FLG_L] = mul_ovf;
  end

  // Increment flags, full 20-bit or 16-bit destination
  always_comb begin
    flags_inc = status_q;
    if (acc_dst) begin
      flags_inc[FLG_C] = sum21[20];
      flags_inc[FLG_V] = (src20 == MAX_POS20);
      flags_inc[FLG_Z] = (sum21[19:0] == 20'h00000);
      flags_inc[FLG_N] = sum21[19];
      // Extension in use when bits 35..31 are not all sign copies
      flags_inc[FLG_E] = ~((&sum21[19:15]) | ~(|sum21[19:15]));
      flags_inc[FLG_U] = ~(sum21[15] ^ sum21[14]);
      flags_inc[FLG_L] = (cmd_q.par & cmd_q.lim) | (src20 == MAX_POS20);
      // Size flag is sticky: bits 30 and 29 of the moved word differ
      flags_inc[FLG_SZ] = status_q[FLG_SZ] |
        (cmd_q.par & (acc_q[acc_sel].upr[14] ^ acc_q[acc_sel].upr[13]));
    end else begin
      flags_inc[FLG_C] = sum17[16];
      flags_inc[FLG_V] = (src16 == MAX_POS16);
      flags_inc[FLG_Z] = (sum17[15:0] == 16'h0000);
      flags_inc[FLG_N] = sum17[15];
      flags_inc[FLG_E] = 1'b0;
      flags_inc[FLG_U] = ~(sum17[15] ^ sum17[14]);
      flags_inc[FLG_L] = (src16 == MAX_POS16);
    end
  end

  // Cycle and word budget of the pending command
  always_comb begin
    cyc_need = CYC_MUL;
    words_need = WORDS_ONE;
    if (cmd_q.op == OP_INC) begin
      if (acc_dst && cmd_q.par) begin
        cyc_need = CYC_INC_PAR;
      end else if (cmd_q.dest != DST_MEM) begin
        cyc_need = CYC_INC_REG;
      end else begin
        unique case (cmd_q.mode)
          AM_STACK: cyc_need = CYC_INC_STACK;
          AM_SHORT: cyc_need = CYC_INC_SHORT;
          // Reserved mode costs the same as full absolute
          default: begin
            cyc_need = CYC_INC_ABS;
            words_need = WORDS_TWO;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, sequencing and register updates
  logic acc_phase;
  logic go;
  logic [31:0] rd_mux;
  logic hit;

  // Accesses stall while a command runs, so operands cannot shift under it
  assign acc_phase = psel & penable & ~pready_q;
  assign go = acc_phase & (state_q == ST_IDLE);

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      OFS_OPND1: rd_mux[15:0] = opnd1_q;
      OFS_OPND2: rd_mux[15:0] = opnd2_q;
      OFS_WREG: rd_mux[15:0] = wreg_q;
      OFS_MEMW: rd_mux[15:0] = memw_q;
      OFS_A_EXT: rd_mux[3:0] = acc_q[0].ext;
      OFS_A_UPR: rd_mux[15:0] = acc_q[0].upr;
      OFS_A_LWR: rd_mux[15:0] = acc_q[0].lwr;
      OFS_B_EXT: rd_mux[3:0] = acc_q[1].ext;
      OFS_B_UPR: rd_mux[15:0] = acc_q[1].upr;
      OFS_B_LWR: rd_mux[15:0] = acc_q[1].lwr;
      OFS_CMD: rd_mux[6:0] = cmd_q;
      OFS_STATUS: rd_mux[15:0] = status_q;
      OFS_INFO: rd_mux[5:0] = {last_words_q, last_cyc_q};
      default: hit = 1'b0;
    endcase
  end

  // Next-state logic for everything
  // Status writes and commits never meet: the bus stalls while a command runs
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    acc_d = acc_q;
    opnd1_d = opnd1_q;
    opnd2_d = opnd2_q;
    wreg_d = wreg_q;
    memw_d = memw_q;
    status_d = status_q;
    cnt_d = cnt_q;
    last_cyc_d = last_cyc_q;
    last_words_d = last_words_q;
    pready_d = go;
    pslverr_d = go & ~hit;
    prdata_d = prdata_q;
    if (go && !pwrite) begin
      prdata_d = rd_mux;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (go && pwrite) begin
          case (paddr)
            OFS_OPND1: opnd1_d = pwdata[15:0];
            OFS_OPND2: opnd2_d = pwdata[15:0];
            OFS_WREG: wreg_d = pwdata[15:0];
            OFS_MEMW: memw_d = pwdata[15:0];
            OFS_A_EXT: acc_d[0].ext = pwdata[3:0];
            OFS_A_UPR: acc_d[0].upr = pwdata[15:0];
            OFS_A_LWR: acc_d[0].lwr = pwdata[15:0];
            OFS_B_EXT: acc_d[1].ext = pwdata[3:0];
            OFS_B_UPR: acc_d[1].upr = pwdata[15:0];
            OFS_B_LWR: acc_d[1].lwr = pwdata[15:0];
            OFS_STATUS: status_d = pwdata[15:0];
            OFS_CMD: begin
              cmd_d = imia_cmd_t'(pwdata[6:0]);
              // Reserved mode behaves as full absolute
              state_d = ST_EXEC;
              cnt_d = 4'h0;
            end
            default: ;
          endcase
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q + 4'h1;
        // Commit on the last oscillator cycle of the budget
        if (cnt_q + 4'h1 == cyc_need) begin
          state_d = ST_IDLE;
          last_cyc_d = cyc_need;
          last_words_d = words_need;
          if (cmd_q.op == OP_MUL) begin
            status_d = flags_mul;
            if (acc_dst) begin
              acc_d[acc_sel].ext = mul20[19:16];
              acc_d[acc_sel].upr = mul16;
            end else if (cmd_q.dest == DST_REG) begin
              wreg_d = mul16;
            end else begin
              memw_d = mul16;
            end
          end else begin
            status_d = flags_inc;
            // Parallel read target is never this accumulator, so no clash here
            if (acc_dst) begin
              acc_d[acc_sel].ext = sum21[19:16];
              acc_d[acc_sel].upr = sum21[15:0];
            end else if (cmd_q.dest == DST_REG) begin
              wreg_d = sum17[15:0];
            end else begin
              memw_d = sum17[15:0];
            end
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Async reset loads constants only; release is taken at the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cmd_q <= imia_cmd_t'(7'h00);
      acc_q[0] <= imia_acc_t'(36'h000000000);
      acc_q[1] <= imia_acc_t'(36'h000000000);
      opnd1_q <= 16'h0000;
      opnd2_q <= 16'h0000;
      wreg_q <= 16'h0000;
      memw_q <= 16'h0000;
      status_q <= STATUS_RST;
      cnt_q <= 4'h0;
      last_cyc_q <= 4'h0;
      last_words_q <= 2'h0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      acc_q <= acc_d;
      opnd1_q <= opnd1_d;
      opnd2_q <= opnd2_d;
      wreg_q <= wreg_d;
      memw_q <= memw_d;
      status_q <= status_d;
      cnt_q <= cnt_d;
      last_cyc_q <= last_cyc_d;
      last_words_q <= last_words_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Bus outputs straight from flops
  // No combinational path from the bus inputs to the answer
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ==== imia_alu_assertions.sv ====
// Bus-side checker for the multiply and increment data ALU
`timescale 1ns/1ps
module imia_alu_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [imia_pkg::ADDR_W-1:0] paddr,
  input wire logic [imia_pkg::DATA_W-1:0] pwdata,
  input wire logic [imia_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import imia_pkg::*;
  ////////////////////////////////////////
  // One clock domain, so one default
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Answers
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_first_wait; $rose(penable) && psel |-> !pready; endproperty
  a_first_wait: assert property (p_first_wait) else $error("no wait state");
  // Stall covers the command time before the next answer
  property p_cmd_stall; pready && pwrite && paddr == OFS_CMD |=> !pready [*2]; endproperty
  a_cmd_stall: assert property (p_cmd_stall) else $error("answer during command");
  // Memory increments hold the bus at least for the short-address budget
  property p_mem_stall;
    pready && pwrite && paddr == OFS_CMD && pwdata[2:0] == 3'h7 |=> !pready [*6];
  endproperty
  a_mem_stall: assert property (p_mem_stall) else $error("memory increment too short");
  // Error response only for unmapped places
  property p_err_map; pslverr |-> pready && (paddr[1:0] != 2'h0 || paddr > 8'h30); endproperty
  a_err_map: assert property (p_err_map) else $error("bad error response");
  property p_ok_map; pready && paddr[1:0] == 2'h0 && paddr <= 8'h30 |-> !pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("error on mapped place");
  // Reserved bits read zero on operands, register, upper words, extensions, status and info
  property p_opnd_rsv; pready && !pwrite && paddr < 8'h08 |-> prdata[31:16] == 16'h0000;
  endproperty
  a_opnd_rsv: assert property (p_opnd_rsv) else $error("operand upper bits");
  property p_upr_rsv; pready && !pwrite && (paddr == 8'h14 || paddr == 8'h20) |->
    prdata[31:16] == 16'h0000; endproperty
  a_upr_rsv: assert property (p_upr_rsv) else $error("upper word bits");
  property p_ext_rsv; pready && !pwrite && (paddr == 8'h10 || paddr == 8'h1c) |->
    prdata[31:4] == 28'h0000000; endproperty
  a_ext_rsv: assert property (p_ext_rsv) else $error("extension bits");
  property p_wreg_rsv; pready && !pwrite && paddr == 8'h08 |-> prdata[31:16] == 16'h0000;
  endproperty
  a_wreg_rsv: assert property (p_wreg_rsv) else $error("register bits");
  property p_info_rsv; pready && !pwrite && paddr == 8'h30 |-> prdata[31:6] == 26'h0;
  endproperty
  a_info_rsv: assert property (p_info_rsv) else $error("info bits");
  property p_stat_rsv; pready && !pwrite && paddr == 8'h2c |-> prdata[31:16] == 16'h0000;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status bits");
  // Main scenarios
  c_cmd: cover property (pready && pwrite && paddr == 8'h28);
  c_err: cover property (pslverr);
  c_stat: cover property (pready && !pwrite && paddr == 8'h2c);
endmodule
bind imia_alu imia_alu_chk imia_alu_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ==== imia_alu_tb.sv ====
// Self-checking bench for the multiply and increment data ALU
`timescale 1ns/1ps
module imia_alu_tb;
  import imia_pkg::*;
  typedef struct packed {
    logic [6:0] cmd;
    logic [15:0] a;
    logic [15:0] b;
    logic [35:0] pre;
    logic [35:0] exp;
    logic [7:0] flg;
    logic [7:0] msk;
    logic [5:0] inf;
  } imia_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int cmp_count = 0;
  imia_row_t rows [16];
  ////////////////////////////////////////
  // Device under test
  imia_alu imia_alu_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // 250 MHz clock
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////
  // APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    // A transfer that never answers counts against the run
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: no pready on transfer", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Compares, masked data and error flag
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    cmp_count++;
    if ((g & m) !== e) begin
      n_mismatch++;
      $display("ERROR %0t: data %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_err(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: pslverr %b expected %b", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
  ////////////////////////////////////////
  // Rows: command, operands, preset, result, flags, flag mask, cycles and words
  initial begin
    imia_row_t r;
    logic [7:0] bs;
    rows[0] = '{7'h00, 16'h3, 16'h4, 36'hf12340033, 36'h0000c0033, 8'h00, 8'h4e, 6'h12};
    rows[1] = '{7'h02, 16'h4, 16'hfffd, 36'h000005555, 36'hffff45555, 8'h08, 8'h4e, 6'h12};
    rows[2] = '{7'h00, 16'h100, 16'h100, 36'h3aaaa0001, 36'h000000001, 8'h46, 8'h4e, 6'h12};
    rows[3] = '{7'h04, 16'h7fff, 16'h2, 36'h0, 36'h00000fffe, 8'h4a, 8'h4e, 6'h12};
    rows[4] = '{7'h01, 16'h0, 16'h0, 36'h000010033, 36'h000020033, 8'h10, 8'h7f, 6'h12};
    rows[5] = '{7'h03, 16'h0, 16'h0, 36'hfffff1234, 36'h000001234, 8'h15, 8'h7f, 6'h12};
    rows[6] = '{7'h01, 16'h0, 16'h0, 36'h7ffff0000, 36'h800000000, 8'h7a, 8'h7f, 6'h12};
    rows[7] = '{7'h01, 16'h0, 16'h0, 36'h07fff0000, 36'h080000000, 8'h20, 8'h7f, 6'h12};
    rows[8] = '{7'h21, 16'h0, 16'h0, 36'h010000000, 36'h010010000, 8'h10, 8'h7f, 6'h12};
    rows[9] = '{7'h61, 16'h0, 16'h0, 36'h010000000, 36'h010010000, 8'h50, 8'h7f, 6'h12};
    rows[10] = '{7'h05, 16'h0, 16'h0, 36'h0ffff, 36'h00000, 8'h05, 8'h6f, 6'h12};
    rows[11] = '{7'h07, 16'h0, 16'h0, 36'h00041, 36'h00042, 8'h00, 8'h6f, 6'h18};
    rows[12] = '{7'h0f, 16'h0, 16'h0, 36'h07fff, 36'h08000, 8'h4a, 8'h6f, 6'h16};
    rows[13] = '{7'h17, 16'h0, 16'h0, 36'h0fffe, 36'h0ffff, 8'h08, 8'h6f, 6'h28};
    rows[14] = '{7'h1f, 16'h0, 16'h0, 36'h01234, 36'h01235, 8'h00, 8'h6f, 6'h28};
    rows[15] = '{7'h21, 16'h0, 16'h0, 36'h040000000, 36'h040010000, 8'h80, 8'hff, 6'h12};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rd(OFS_STATUS);
    chk(rdat, 32'h0, 32'hffffffff);
    rd(OFS_INFO);
    chk(rdat, 32'h0, 32'hffffffff);
    // Table loop; no parallel read ever names the result register
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      bs = (r.cmd[2:1] == 2'h0) ? OFS_A_EXT : (r.cmd[2:1] == 2'h1) ? OFS_B_EXT :
        (r.cmd[1] ? OFS_MEMW : OFS_WREG);
      wr(OFS_OPND1, {16'h0, r.a});
      wr(OFS_OPND2, {16'h0, r.b});
      wr(OFS_STATUS, 32'h0);
      if (r.cmd[2]) begin
        wr(bs, {16'h0, r.pre[15:0]});
      end else begin
        wr(bs, {28'h0, r.pre[35:32]});
        wr(bs + 8'h04, {16'h0, r.pre[31:16]});
        wr(bs + 8'h08, {16'h0, r.pre[15:0]});
      end
      wr(OFS_CMD, {25'h0, r.cmd});
      rd(bs);
      if (r.cmd[2]) begin
        chk(rdat, {16'h0, r.exp[15:0]}, 32'hffff);
      end else begin
        chk(rdat, {28'h0, r.exp[35:32]}, 32'hf);
        rd(bs + 8'h04);
        chk(rdat, {16'h0, r.exp[31:16]}, 32'hffff);
        rd(bs + 8'h08);
        chk(rdat, {16'h0, r.exp[15:0]}, 32'hffff);
      end
      rd(OFS_STATUS);
      chk(rdat, {24'h0, r.flg}, {24'h0, r.msk});
      rd(OFS_INFO);
      chk(rdat, {26'h0, r.inf}, 32'h3f);
    end
    // Reset in mid-run clears the first operand and the flags left by the last row
    wr(OFS_OPND1, 32'h1234);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_OPND1);
    chk(rdat, 32'h0, 32'hffffffff);
    rd(OFS_STATUS);
    chk(rdat, 32'h0, 32'hffffffff);
    // Unmapped and misaligned places
    rd(8'h34);
    chk_err(rerr, 1'b1);
    chk(rdat, 32'h0, 32'hffffffff);
    wr(8'h02, 32'h1234);
    chk_err(rerr, 1'b1);
    // Extension holds four bits only
    wr(OFS_A_EXT, 32'hffffffff);
    rd(OFS_A_EXT);
    chk(rdat, 32'hf, 32'hffffffff);
    chk_err(rerr, 1'b0);
    // Mode byte is plain storage
    wr(OFS_STATUS, 32'h0000ab00);
    rd(OFS_STATUS);
    chk(rdat, 32'hab00, 32'hff00);
    final_report;
  end
endmodule
